// *** hw/tws_slave.sv ***
// Functional notes
// - slave only, standard and fast rates
// - seven-bit address, answers only 1101011
// - start is sda falling while scl high
// - transmitter changes sda only scl low
// - address ack only on match, ninth clock
// - receiver acks each byte, unlimited bytes
// - stop releases bus, await new start
// - stop returns state machine to idle
// - unmapped register reads return ffh
// - master code not acked, enters high-speed
// - repeated start, then normal protocol
// - stop ends high-speed mode
// - master chains repeated starts in high-speed
// - high-speed guaranteed for writes only
`timescale 1ns/1ps
module tws_slave
(
	input  wire logic       clk,
	input  wire logic       rstn,
	tws_bus_if.slave        bus,
	output logic [7:0]      regData [tws_pkg::REG_COUNT],
	output logic            hsMode,
	output logic            writeStrobe,
	output logic [7:0]      writeIndex
);
	typedef struct packed
	{
		logic                  sclPrev;
		logic                  sdaPrev;
		tws_pkg::tws_state_t   state;
		logic [3:0]            bitCount;
		logic [7:0]            shift;
		logic                  readDir;
		logic                  havePointer;
		logic [7:0]            pointer;
		logic                  sdaOen;
		logic                  hsMode;
		logic                  writeStrobe;
		logic [7:0]            writeIndex;
		logic [tws_pkg::REG_COUNT*8-1:0] regs;
	} tws_slave_t;

	tws_slave_t q;
	tws_slave_t next_q;
	logic       sclSync;
	logic       sdaSync;

	tws_sync sclSyncer
	(
		.clk  (clk),
		.rstn (rstn),
		.din  (bus.scl),
		.dout (sclSync)
	);
	tws_sync sdaSyncer
	(
		.clk  (clk),
		.rstn (rstn),
		.din  (bus.sda),
		.dout (sdaSync)
	);

	function automatic logic [7:0] readReg(input logic [tws_pkg::REG_COUNT*8-1:0] regs, input logic [7:0] idx);
		logic [7:0] value;
		value = tws_pkg::UNMAPPED_VALUE;
		for (int i = 0; i < tws_pkg::REG_COUNT; i++)
			if (idx == 8'(i))
				value = regs[i*8 +: 8];
		return value;
	endfunction

	localparam logic [tws_pkg::REG_COUNT*8-1:0] REGS_RESET =
		{tws_pkg::REG4_RESET, tws_pkg::REG3_RESET, tws_pkg::REG2_RESET, tws_pkg::REG1_RESET, tws_pkg::REG0_RESET};

	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	always_comb
	begin
		sclRise   = sclSync && !q.sclPrev;
		sclFall   = !sclSync && q.sclPrev;
		startSeen = sclSync && q.sclPrev && q.sdaPrev && !sdaSync;
		stopSeen  = sclSync && q.sclPrev && !q.sdaPrev && sdaSync;
		next_q = q;
		next_q.sclPrev     = sclSync;
		next_q.sdaPrev     = sdaSync;
		next_q.writeStrobe = 1'b0;
		if (stopSeen)
		begin
			next_q.state  = tws_pkg::TWS_IDLE;
			next_q.sdaOen = 1'b1;
			next_q.hsMode = 1'b0;
		end
		else if (startSeen)
		begin
			next_q.state    = tws_pkg::TWS_ADDR;
			next_q.bitCount = 4'h0;
			next_q.sdaOen   = 1'b1;
		end
		else
		begin
			case (q.state)
			tws_pkg::TWS_ADDR, tws_pkg::TWS_RX:
				if (sclRise)
				begin
					// sampled on the rising edge since sda is stable while high
					next_q.shift    = {q.shift[6:0], sdaSync};
					next_q.bitCount = q.bitCount + 4'h1;
				end
				else if (sclFall && q.bitCount == 4'h8)
				begin
					next_q.bitCount = 4'h0;
					if (q.state == tws_pkg::TWS_ADDR)
					begin
						if (q.shift[7:3] == tws_pkg::HS_CODE_PREFIX)
						begin
							next_q.hsMode = 1'b1;
							next_q.state  = tws_pkg::TWS_SKIP;
						end
						else if (q.shift[7:1] == tws_pkg::SLAVE_ADDR)
						begin
							next_q.readDir = q.shift[0];
							next_q.sdaOen  = 1'b0;
							next_q.state   = tws_pkg::TWS_AACK;
							if (!q.shift[0])
								next_q.havePointer = 1'b0;
						end
						else
							next_q.state = tws_pkg::TWS_SKIP;
					end
					else
					begin
						next_q.sdaOen = 1'b0;
						next_q.state  = tws_pkg::TWS_RACK;
						if (!q.havePointer)
						begin
							next_q.pointer     = q.shift;
							next_q.havePointer = 1'b1;
						end
						else
						begin
							for (int i = 0; i < tws_pkg::REG_COUNT; i++)
								if (q.pointer == 8'(i))
									next_q.regs[i*8 +: 8] = q.shift;
							next_q.writeStrobe = 1'b1;
							next_q.writeIndex  = q.pointer;
							next_q.pointer     = q.pointer + 8'h1;
						end
					end
				end
			tws_pkg::TWS_AACK, tws_pkg::TWS_RACK:
				if (sclFall)
				begin
					next_q.sdaOen = 1'b1;
					if (q.state == tws_pkg::TWS_AACK && q.readDir)
					begin
						// reads are served at f/s rates; hs reads not guaranteed
						next_q.shift  = readReg(q.regs, q.pointer);
						next_q.sdaOen = readReg(q.regs, q.pointer) >> 7 == 8'h1 ? 1'b1 : 1'b0;
						next_q.state  = tws_pkg::TWS_TX;
					end
					else
						next_q.state = tws_pkg::TWS_RX;
				end
			tws_pkg::TWS_TX:
				if (sclFall)
				begin
					next_q.bitCount = q.bitCount + 4'h1;
					next_q.shift    = {q.shift[6:0], 1'b1};
					if (q.bitCount == 4'h7)
					begin
						next_q.sdaOen = 1'b1;
						next_q.state  = tws_pkg::TWS_TACK;
					end
					else
						next_q.sdaOen = q.shift[6];
				end
			tws_pkg::TWS_TACK:
				if (sclRise)
				begin
					next_q.bitCount = 4'h0;
					if (sdaSync)
						next_q.state = tws_pkg::TWS_SKIP;
					else
					begin
						next_q.pointer = q.pointer + 8'h1;
						next_q.state   = tws_pkg::TWS_AACK;
						next_q.readDir = 1'b1;
					end
				end
			default:
				next_q.sdaOen = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q             <= '0;
			q.sclPrev     <= 1'b1;
			q.sdaPrev     <= 1'b1;
			q.sdaOen      <= 1'b1;
			q.regs        <= REGS_RESET;
		end
		else
			q <= next_q;
	end

	// only low is ever driven; enable alone carries the bit
	assign bus.sdaSlaveOut = 1'b0;
	assign bus.sdaSlaveOen = q.sdaOen;
	assign hsMode          = q.hsMode;
	assign writeStrobe     = q.writeStrobe;
	assign writeIndex      = q.writeIndex;
	always_comb
		for (int i = 0; i < tws_pkg::REG_COUNT; i++)
			regData[i] = q.regs[i*8 +: 8];
endmodule

// *** hw/tws_pkg.sv ***
package tws_pkg;
	localparam logic [6:0] SLAVE_ADDR     = 7'h6b;
	localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
	localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
	localparam int         REG_COUNT      = 5;
	localparam logic [7:0] REG0_RESET     = 8'h40;
	localparam logic [7:0] REG1_RESET     = 8'h30;
	localparam logic [7:0] REG2_RESET     = 8'h14;
	// value arbitrary: stands in for an identity byte
	localparam logic [7:0] REG3_RESET     = 8'h5c;
	localparam logic [7:0] REG4_RESET     = 8'hab;
	localparam int         CLK_MHZ        = 200;
	localparam int         FS_KBPS        = 100;
	localparam int         HALF_BIT       = (CLK_MHZ * 1000) / (FS_KBPS * 2);

	typedef enum logic [2:0]
	{
		TWS_IDLE = 3'b000,
		TWS_ADDR = 3'b001,
		TWS_AACK = 3'b010,
		TWS_RX   = 3'b011,
		TWS_RACK = 3'b100,
		TWS_TX   = 3'b101,
		TWS_TACK = 3'b110,
		TWS_SKIP = 3'b111
	} tws_state_t;

	typedef enum logic [3:0]
	{
		TWM_IDLE  = 4'h0,
		TWM_START = 4'h1,
		TWM_LOW   = 4'h2,
		TWM_HIGH  = 4'h3,
		TWM_STOP0 = 4'h4,
		TWM_STOP1 = 4'h5,
		TWM_STOP2 = 4'h6,
		TWM_DONE   = 4'h7,
		TWM_RSETUP = 4'h8,
		TWM_RHIGH  = 4'h9
	} tws_mstate_t;
endpackage

// *** hw/tws_bus_if.sv ***
`timescale 1ns/1ps
interface tws_bus_if;
	logic sclOut;
	logic sclOen;
	logic sdaMasterOut;
	logic sdaMasterOen;
	logic sdaSlaveOut;
	logic sdaSlaveOen;
	logic scl;
	logic sda;

	// open drain with pull-up: low wins when any enable is low
	assign scl = (sclOen == 1'b0) ? sclOut : 1'b1;
	assign sda = ((sdaMasterOen == 1'b0 && sdaMasterOut == 1'b0)
		|| (sdaSlaveOen == 1'b0 && sdaSlaveOut == 1'b0)) ? 1'b0 : 1'b1;

	modport slave
	(
		input  scl,
		input  sda,
		output sdaSlaveOut,
		output sdaSlaveOen
	);
	modport master
	(
		input  scl,
		input  sda,
		output sclOut,
		output sclOen,
		output sdaMasterOut,
		output sdaMasterOen
	);
endinterface

// *** hw/tws_sync.sv ***
`timescale 1ns/1ps
module tws_sync
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed
	{
		logic stage1;
		logic stage2;
	} tws_sync_t;

	tws_sync_t q;
	tws_sync_t next_q;

	always_comb
	begin
		next_q.stage1 = din;
		next_q.stage2 = q.stage1;
	end

	// idle bus is high, so reset to high avoids a false start
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q <= 2'b11;
		else
			q <= next_q;
	end

	assign dout = q.stage2;
endmodule

// *** hw/tws_master.sv ***
`timescale 1ns/1ps
module tws_master #(
	parameter int HALF_BIT = tws_pkg::HALF_BIT
)
(
	input  wire logic       clk,
	input  wire logic       rstn,
	tws_bus_if.master       bus,
	input  wire logic       reqValid,
	input  wire logic [7:0] reqByte,
	input  wire logic       reqLast,
	output logic            reqReady,
	output logic [7:0]      rxByte,
	output logic            ackSeen,
	output logic            byteDone,
	output logic            idle
);
	if (HALF_BIT < 4 || HALF_BIT > 65535)
	begin
		$error("HALF_BIT out of range");
	end

	typedef struct packed
	{
		tws_pkg::tws_mstate_t state;
		logic [15:0]          timer;
		logic [3:0]           bitIdx;
		logic [8:0]           shift;
		logic                 last;
		logic                 sclOen;
		logic                 sdaOen;
		logic                 reqReady;
		logic [7:0]           rxByte;
		logic                 ackSeen;
		logic                 byteDone;
		logic                 idle;
	} tws_master_t;

	tws_master_t q;
	tws_master_t next_q;
	logic        sdaSync;

	tws_sync sdaSyncer
	(
		.clk  (clk),
		.rstn (rstn),
		.din  (bus.sda),
		.dout (sdaSync)
	);

	logic expired;

	always_comb
	begin
		expired = (q.timer == 16'(HALF_BIT - 1));
		next_q = q;
		next_q.timer    = expired ? 16'h0 : q.timer + 16'h1;
		next_q.reqReady = 1'b0;
		next_q.byteDone = 1'b0;
		case (q.state)
		tws_pkg::TWM_IDLE, tws_pkg::TWM_DONE:
		begin
			next_q.timer = 16'h0;
			if (reqValid)
			begin
				// byte plus released ack slot
				next_q.shift    = {reqByte, 1'b1};
				next_q.last     = reqLast;
				next_q.reqReady = 1'b1;
				next_q.bitIdx   = 4'h0;
				if (q.state == tws_pkg::TWM_IDLE)
				begin
					next_q.sdaOen = 1'b0;
					next_q.state  = tws_pkg::TWM_START;
				end
				else if (!q.ackSeen)
				begin
					// nobody acked: repeated start, since a stop would end hs mode
					next_q.sdaOen = 1'b1;
					next_q.state  = tws_pkg::TWM_RSETUP;
				end
				else
					next_q.state = tws_pkg::TWM_LOW;
			end
		end
		tws_pkg::TWM_RSETUP:
			if (expired)
			begin
				next_q.sclOen = 1'b1;
				next_q.state  = tws_pkg::TWM_RHIGH;
			end
		tws_pkg::TWM_RHIGH:
			if (expired)
			begin
				next_q.sdaOen = 1'b0;
				next_q.state  = tws_pkg::TWM_START;
			end
		tws_pkg::TWM_START:
			if (expired)
			begin
				next_q.sclOen = 1'b0;
				next_q.state  = tws_pkg::TWM_LOW;
			end
		tws_pkg::TWM_LOW:
		begin
			// data moves after scl has fallen, never with it, so skew cannot fake a start or stop
			if (q.timer == 16'h1)
				next_q.sdaOen = q.shift[8];
			if (expired)
			begin
				next_q.sclOen = 1'b1;
				next_q.state  = tws_pkg::TWM_HIGH;
			end
		end
		tws_pkg::TWM_HIGH:
			if (expired)
			begin
				next_q.sclOen = 1'b0;
				next_q.shift  = {q.shift[7:0], 1'b1};
				next_q.bitIdx = q.bitIdx + 4'h1;
				next_q.rxByte = {q.rxByte[6:0], sdaSync};
				next_q.state  = tws_pkg::TWM_LOW;
				if (q.bitIdx == 4'h8)
				begin
					next_q.rxByte   = q.rxByte;
					next_q.ackSeen  = !sdaSync;
					next_q.byteDone = 1'b1;
					next_q.state    = q.last ? tws_pkg::TWM_STOP0 : tws_pkg::TWM_DONE;
				end
			end
		tws_pkg::TWM_STOP0:
		begin
			if (q.timer == 16'h1)
				next_q.sdaOen = 1'b0;
			if (expired)
			begin
				next_q.sclOen = 1'b1;
				next_q.state  = tws_pkg::TWM_STOP1;
			end
		end
		tws_pkg::TWM_STOP1:
			if (expired)
			begin
				next_q.sdaOen = 1'b1;
				next_q.state  = tws_pkg::TWM_STOP2;
			end
		default:
			if (expired)
				next_q.state = tws_pkg::TWM_IDLE;
		endcase
		next_q.idle = (next_q.state == tws_pkg::TWM_IDLE);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q        <= '0;
			q.sclOen <= 1'b1;
			q.sdaOen <= 1'b1;
			q.shift  <= 9'h1ff;
			q.idle   <= 1'b1;
		end
		else
			q <= next_q;
	end

	assign bus.sclOut       = 1'b0;
	assign bus.sclOen       = q.sclOen;
	assign bus.sdaMasterOut = 1'b0;
	assign bus.sdaMasterOen = q.sdaOen;
	assign reqReady         = q.reqReady;
	assign rxByte           = q.rxByte;
	assign ackSeen          = q.ackSeen;
	assign byteDone         = q.byteDone;
	assign idle             = q.idle;
endmodule

// *** tb/tws_bus_sva.sv ***
`timescale 1ns/1ps
module tws_bus_sva
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaSlaveOen
);
	logic       sclQ;
	logic       sdaQ;
	logic       first;
	logic       hit;
	logic       rd;
	logic [3:0] cnt;
	logic [7:0] sh;
	wire        rise  = scl & ~sclQ;
	wire        begun = scl & sclQ & sdaQ & ~sda;
	wire        ninth = rise & (cnt == 4'h8);

	// byte tracker restarts at every start, so a stray byte cannot shift the count
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclQ  <= 1'b1;
			sdaQ  <= 1'b1;
			first <= 1'b0;
			hit   <= 1'b0;
			rd    <= 1'b0;
			cnt   <= 4'h0;
			sh    <= 8'h00;
		end
		else
		begin
			sclQ <= scl;
			sdaQ <= sda;
			if (begun)
			begin
				cnt   <= 4'h0;
				first <= 1'b1;
			end
			else if (rise)
			begin
				cnt <= ninth ? 4'h0 : cnt + 4'h1;
				if (!ninth)
					sh <= {sh[6:0], sda};
				if (ninth)
					first <= 1'b0;
				if (ninth && first)
				begin
					hit <= (sh[7:1] == tws_pkg::SLAVE_ADDR);
					rd  <= sh[0];
				end
			end
		end
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence startSeq;
		scl && $fell(sda);
	endsequence
	sequence stopSeq;
		scl && $rose(sda);
	endsequence

	slave_hold_a: assert property ($changed(sdaSlaveOen) |-> !scl)
		else $error("slave sda moved while scl high");
	start_free_a: assert property (startSeq |-> sdaSlaveOen)
		else $error("slave drives sda at start");
	stop_release_a: assert property (stopSeq |=> sdaSlaveOen [*8])
		else $error("slave holds sda after stop");
	addr_ack_a: assert property (ninth && first && sh[7:1] == tws_pkg::SLAVE_ADDR |-> !sda)
		else $error("own address not acked");
	addr_nack_a: assert property (ninth && first && sh[7:1] != tws_pkg::SLAVE_ADDR |-> sda)
		else $error("foreign address acked");
	hs_nack_a: assert property (ninth && first && sh[7:3] == tws_pkg::HS_CODE_PREFIX |-> sda)
		else $error("master code acked");
	write_ack_a: assert property (ninth && !first && hit && !rd |-> !sda)
		else $error("written byte not acked");
	read_free_a: assert property (ninth && !first && hit && rd |-> sdaSlaveOen)
		else $error("slave drives master ack slot");
	ignore_bus_a: assert property (ninth && !first && !hit |-> sdaSlaveOen)
		else $error("slave acks after foreign address");
endmodule

// *** tb/tws_tb.sv ***
`timescale 1ns/1ps
module tws_tb;
	logic       clk;
	logic       rstn;
	logic       reqValid;
	logic [7:0] reqByte;
	logic       reqLast;
	logic       reqReady;
	logic [7:0] rxByte;
	logic       ackSeen;
	logic       byteDone;
	logic       idle;
	logic       hsMode;
	logic       writeStrobe;
	logic [7:0] writeIndex;
	logic [7:0] regData [tws_pkg::REG_COUNT];
	logic [7:0] rx;
	logic       ack;
	int         errTotal;
	int         numChecks;
	int         strobes = 0;

	tws_bus_if bus ();
	tws_slave i_tws_slave (.clk(clk), .rstn(rstn), .bus(bus.slave), .regData(regData), .hsMode(hsMode),
		.writeStrobe(writeStrobe), .writeIndex(writeIndex));
	tws_master #(.HALF_BIT(8)) i_tws_master (.clk(clk), .rstn(rstn), .bus(bus.master), .reqValid(reqValid),
		.reqByte(reqByte), .reqLast(reqLast), .reqReady(reqReady), .rxByte(rxByte), .ackSeen(ackSeen),
		.byteDone(byteDone), .idle(idle));
	tws_bus_sva i_tws_bus_sva (.clk(clk), .rstn(rstn), .scl(bus.scl), .sda(bus.sda), .sdaSlaveOen(bus.sdaSlaveOen));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
		if (writeStrobe === 1'b1)
			strobes <= strobes + 1;

	task automatic reportAndStop();
		if (errTotal == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			errTotal++;
		end
	endtask

	// 0 ready, 1 byte done, 2 idle; looked at on the falling edge once pulses settle
	task automatic waitFor(input int which);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (n < 400 && (which == 0 ? reqReady : which == 1 ? byteDone : idle) !== 1'b1);
		if (n >= 400)
		begin
			$display("BAD wait %0d expected 1 seen 0", which);
			errTotal++;
			reportAndStop();
		end
	endtask

	task automatic xfer(input logic [7:0] b, input logic last);
		@(posedge clk);
		reqValid <= 1'b1;
		reqByte  <= b;
		reqLast  <= last;
		waitFor(0);
		@(posedge clk);
		reqValid <= 1'b0;
		waitFor(1);
		rx  = rxByte;
		ack = ackSeen;
		if (last)
			waitFor(2);
	endtask

	task automatic readReg(input logic [7:0] ptr, input logic [7:0] exp);
		xfer({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
		xfer(ptr, 1'b1);
		xfer({tws_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
		chk("read addr ack", 8'h01, {7'h00, ack});
		xfer(8'hff, 1'b1);
		chk("read data", exp, rx);
	endtask

	task automatic resetRead();
		logic [7:0] val [7];
		val = '{tws_pkg::REG0_RESET, tws_pkg::REG1_RESET, tws_pkg::REG2_RESET, tws_pkg::REG3_RESET,
			tws_pkg::REG4_RESET, tws_pkg::UNMAPPED_VALUE, tws_pkg::UNMAPPED_VALUE};
		for (int i = 0; i < 7; i++)
			readReg(i == 6 ? 8'hff : 8'(i), val[i]);
	endtask

	task automatic writeBurst();
		xfer({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
		chk("addr ack", 8'h01, {7'h00, ack});
		xfer(8'h01, 1'b0);
		xfer(8'h5a, 1'b0);
		chk("data ack", 8'h01, {7'h00, ack});
		xfer(8'ha5, 1'b1);
		chk("strobes", 8'h02, 8'(strobes));
		chk("index", 8'h02, writeIndex);
		chk("reg1", 8'h5a, regData[1]);
		readReg(8'h02, 8'ha5);
	endtask

	task automatic wrongAddr();
		xfer({7'h6a, 1'b0}, 1'b0);
		chk("foreign ack", 8'h00, {7'h00, ack});
		xfer(8'h33, 1'b1);
		chk("foreign rs ack", 8'h00, {7'h00, ack});
		chk("foreign strobes", 8'h02, 8'(strobes));
	endtask

	task automatic hsEntry();
		for (int c = 0; c < 8; c++)
		begin
			xfer({tws_pkg::HS_CODE_PREFIX, 3'(c)}, 1'b0);
			chk("code ack", 8'h00, {7'h00, ack});
			chk("hs on", 8'h01, {7'h00, hsMode});
			xfer({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
			chk("hs addr ack", 8'h01, {7'h00, ack});
			chk("hs kept", 8'h01, {7'h00, hsMode});
			xfer(8'h04, 1'b0);
			xfer({5'h18, 3'(c)}, 1'b1);
			chk("hs write", {5'h18, 3'(c)}, regData[4]);
			chk("hs off", 8'h00, {7'h00, hsMode});
		end
	endtask

	task automatic abortRecover();
		xfer({tws_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
		readReg(8'h01, 8'h5a);
	endtask

	initial
	begin
		rstn      = 1'b0;
		reqValid  = 1'b0;
		reqByte   = 8'h00;
		reqLast   = 1'b0;
		errTotal  = 0;
		numChecks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		resetRead();
		writeBurst();
		wrongAddr();
		hsEntry();
		abortRecover();
		reportAndStop();
	end
endmodule
